// ---- logic/cmp_pkg.sv ----
// Purpose: shared constants, types and state for the output compare channel
// Assumes: 32-bit APB register bus, one 250 MHz clock shared with the timers
// Notes: register offsets are byte addresses, one aligned word each
package cmp_pkg;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int NUM_CHANNELS = 5;
    localparam int FAULT_A_LAST = 4; // last channel served by fault input a

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CMP_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] SEC_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] MASK_OFS = 8'h10;

    // control register field positions
    localparam int IDLE_BIT = 13;
    localparam int FLT_BIT = 4;
    localparam int TSEL_BIT = 3;
    localparam int MODE_LSB = 0;

    // event bits of status and mask
    localparam int EV_W = 2;
    localparam int EV_CMP = 0;
    localparam int EV_FLT = 1;

    // reset values
    localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
    localparam logic [CNT_W-1:0] SEC_RST = 16'h0000;
    localparam logic [EV_W-1:0] MASK_RST = 2'h0;

    typedef enum logic [2:0] {
        M_DIS = 3'h0,
        M_SET_HI = 3'h1,
        M_SET_LO = 3'h2,
        M_TOGGLE = 3'h3,
        M_SINGLE = 3'h4,
        M_CONT = 3'h5,
        M_PWM = 3'h6,
        M_PWM_FLT = 3'h7
    } mode_e;

    typedef enum logic [2:0] {
        PS_ARMED = 3'h1,
        PS_HIGH = 3'h2,
        PS_DONE = 3'h4
    } pulse_e;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic period; // one-cycle pulse at the timer's period rollover
    } timer_s;

    typedef struct packed {
        logic idle_stop;
        logic tsel;
        mode_e mode;
        logic flt;
        logic [CNT_W-1:0] cmp;
        logic [CNT_W-1:0] sec;
        logic [CNT_W-1:0] duty;
        logic out;
        pulse_e pulse;
        logic match_prev;
        logic smatch_prev;
        logic dmatch_prev;
        logic [EV_W-1:0] stat;
        logic [EV_W-1:0] mask;
        logic [31:0] prdata;
    } chan_state_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_s;
endpackage : cmp_pkg

// ---- logic/level_sync.sv ----
// Purpose: bring an asynchronous pin level into the clock domain
// Assumes: the pin may change at any time relative to ref_clk_i
// Notes: the level moves only once the second and third stages agree
`timescale 1ns/1ns
module level_sync
    import cmp_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    output logic level_o
);
    sync_state_s q;
    sync_state_s d;

    // first stage feeds only the second; the filter looks at stages two and three
    always_comb begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.level = q.s3;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL, level: RESET_LEVEL};
        end else begin
            q <= d;
        end
    end

    assign level_o = q.level;
endmodule : level_sync

// ---- logic/output_compare_channel.sv ----
// Purpose: one output compare channel with APB registers and a level interrupt
// Assumes: timer counts and period pulses come from logic on ref_clk_i
// Notes: fault pins are active low and asynchronous; pready is always high
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module output_compare_channel
    import cmp_pkg::*;
#(
    parameter int CHANNEL = 1
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire timer_s timer2_i,
    input wire timer_s timer3_i,
    input wire logic cpu_idle_i,
    input wire logic fault_input_a_n_i,
    input wire logic fault_input_b_n_i,
    output logic compare_output_pin_o,
    output logic irq_o
);
    // refuse a channel number that no fault input serves
    if (CHANNEL < 1 || CHANNEL > NUM_CHANNELS) begin : g_bad_channel
        $error("CHANNEL must lie between 1 and 5");
    end

    chan_state_s q;
    chan_state_s d;
    logic fault_pin_n;
    logic fault_level_n;
    logic acc;
    logic ctrl_wr;
    logic stat_rd;
    logic hit;
    logic halt;
    logic fault;
    timer_s tm;
    logic match;
    logic ev;
    logic sev;
    logic dev;
    logic [EV_W-1:0] events;

    // channels one to four watch input a, channel five watches input b
    assign fault_pin_n = (CHANNEL <= FAULT_A_LAST) ? fault_input_a_n_i : fault_input_b_n_i;

    level_sync #(
        .RESET_LEVEL(1'b1)
    ) u_fault_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .pin_i(fault_pin_n),
        .level_o(fault_level_n)
    );

    // bus decode; zero wait states so every access ends in its first access cycle
    assign acc = psel && penable;
    assign hit = (paddr == CTRL_OFS) || (paddr == CMP_OFS) || (paddr == SEC_OFS)
        || (paddr == STAT_OFS) || (paddr == MASK_OFS);
    assign ctrl_wr = acc && pwrite && (paddr == CTRL_OFS);
    assign stat_rd = acc && !pwrite && (paddr == STAT_OFS);
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata = q.prdata;

    // halted channel freezes its output except on a mode-changing control write, and ignores compare events
    assign halt = q.idle_stop && cpu_idle_i;
    assign fault = !fault_level_n;
    assign tm = q.tsel ? timer3_i : timer2_i;
    assign match = (tm.count == q.cmp);
    // an equal count that lingers over several cycles raises one event only
    assign ev = match && !q.match_prev;
    assign sev = (tm.count == q.sec) && !q.smatch_prev;
    assign dev = (tm.count == q.duty) && !q.dmatch_prev;

    always_comb begin
        d = q;
        events = '0;
        d.match_prev = match;
        d.smatch_prev = (tm.count == q.sec);
        d.dmatch_prev = (tm.count == q.duty);

        // compare-driven output behaviour per mode
        if (!halt) begin
            unique case (q.mode)
                M_DIS: begin
                    d.out = 1'b0;
                end
                M_SET_HI: begin
                    if (ev) begin
                        d.out = 1'b1;
                        events[EV_CMP] = 1'b1;
                    end
                end
                M_SET_LO: begin
                    if (ev) begin
                        d.out = 1'b0;
                        events[EV_CMP] = 1'b1;
                    end
                end
                M_TOGGLE: begin
                    if (ev) begin
                        d.out = !q.out;
                        events[EV_CMP] = 1'b1;
                    end
                end
                M_SINGLE, M_CONT: begin
                    // rise on the primary compare, fall on the secondary
                    unique case (q.pulse)
                        PS_ARMED: begin
                            if (ev) begin
                                d.out = 1'b1;
                                d.pulse = PS_HIGH;
                            end
                        end
                        PS_HIGH: begin
                            if (sev) begin
                                d.out = 1'b0;
                                events[EV_CMP] = 1'b1;
                                d.pulse = (q.mode == M_CONT) ? PS_ARMED : PS_DONE;
                            end
                        end
                        PS_DONE: begin
                            d.out = 1'b0;
                        end
                        default: begin
                            d.out = 1'b0;
                            d.pulse = PS_DONE;
                        end
                    endcase
                end
                M_PWM, M_PWM_FLT: begin
                    // duty reloads only at the period so a write never glitches a cycle
                    if (tm.period) begin
                        d.duty = q.sec;
                        d.out = (q.sec != '0);
                    end else if (dev) begin
                        d.out = 1'b0;
                        events[EV_CMP] = 1'b1;
                    end
                    if (q.mode == M_PWM_FLT) begin
                        if (fault) begin
                            d.out = 1'b0;
                            d.flt = 1'b1;
                        end else if (tm.period) begin
                            d.flt = 1'b0;
                        end
                        // output stays low until the flag clears at a quiet period start
                        if (q.flt && !(tm.period && !fault)) begin
                            d.out = 1'b0;
                        end
                    end
                end
                default: begin
                    d.out = 1'b0;
                end
            endcase
        end

        // flag only has meaning with the fault input enabled
        if (q.mode != M_PWM_FLT) begin
            d.flt = 1'b0;
        end
        if (d.flt && !q.flt) begin
            events[EV_FLT] = 1'b1;
        end

        // register writes; the fault flag is not writable
        if (acc && pwrite) begin
            unique case (paddr)
                CTRL_OFS: begin
                    d.idle_stop = pwdata[IDLE_BIT];
                    d.tsel = pwdata[TSEL_BIT];
                    d.mode = mode_e'(pwdata[MODE_LSB+:3]);
                    if (pwdata[MODE_LSB+:3] != q.mode) begin
                        d.out = (pwdata[MODE_LSB+:3] == M_SET_LO);
                        d.pulse = PS_ARMED;
                        d.flt = 1'b0;
                    end
                end
                CMP_OFS: d.cmp = pwdata[CNT_W-1:0];
                SEC_OFS: d.sec = pwdata[CNT_W-1:0];
                MASK_OFS: d.mask = pwdata[EV_W-1:0];
                default: begin
                end
            endcase
        end

        // a read clears only the bits it returned, so an event after the setup cycle survives
        d.stat = (stat_rd ? (q.stat & ~q.prdata[EV_W-1:0]) : q.stat) | events;

        // read data is captured in the setup cycle and held through the access
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                CTRL_OFS: d.prdata = {18'h00000, q.idle_stop, 8'h00, q.flt, q.tsel, q.mode};
                CMP_OFS: d.prdata = {16'h0000, q.cmp};
                SEC_OFS: d.prdata = {16'h0000, q.sec};
                STAT_OFS: d.prdata = {30'h00000000, q.stat};
                MASK_OFS: d.prdata = {30'h00000000, q.mask};
                default: d.prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '{idle_stop: 1'b0, tsel: 1'b0, mode: M_DIS, flt: 1'b0, cmp: CMP_RST,
                sec: SEC_RST, duty: SEC_RST, out: 1'b0, pulse: PS_ARMED, match_prev: 1'b0,
                smatch_prev: 1'b0, dmatch_prev: 1'b0, stat: '0, mask: MASK_RST,
                prdata: 32'h00000000};
        end else begin
            q <= d;
        end
    end

    assign compare_output_pin_o = q.out;
    // level interrupt while any unmasked status bit stands
    assign irq_o = |(q.stat & q.mask);

    a_idle_freeze: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        halt && !ctrl_wr |=> $stable(q.out))
        else $error("output moved while halted in idle");

    a_flag_hw_set: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(q.flt) |-> $past(q.mode) == M_PWM_FLT && $past(fault) && !$past(halt))
        else $error("fault flag set without a pwm fault");

    a_flag_unused: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode != M_PWM_FLT && $past(q.mode) != M_PWM_FLT |-> !q.flt)
        else $error("fault flag set outside pwm fault mode");

    a_timer3_toggle: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.tsel && !halt && q.mode == M_TOGGLE && timer3_i.count == q.cmp && !q.match_prev && !ctrl_wr
        |=> q.out != $past(q.out))
        else $error("timer 3 compare did not toggle the output");

    a_fault_stops: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_PWM_FLT && fault && !halt && !ctrl_wr |=> !q.out && q.flt)
        else $error("fault did not stop the pwm output");

    a_pwm_ignores: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_PWM && tm.period && q.sec != '0 && !halt && !ctrl_wr |=> q.out && !q.flt)
        else $error("pwm without fault input did not start its period high");

    a_cont_rearm: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_CONT && q.pulse == PS_HIGH && sev && !halt && !ctrl_wr
        |=> !q.out && q.pulse == PS_ARMED)
        else $error("continuous pulse mode did not rearm");

    a_single_done: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_SINGLE && q.pulse == PS_DONE && !ctrl_wr |=> !q.out [*2])
        else $error("single pulse mode made a second pulse");

    a_set_low_init: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ctrl_wr && pwdata[MODE_LSB+:3] == M_SET_LO && q.mode != M_SET_LO |=> q.out)
        else $error("set-low mode did not start high");

    a_set_high_ev: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_SET_HI && ev && !halt && !ctrl_wr |=> q.out && q.stat[EV_CMP])
        else $error("set-high compare event missed");

    a_disabled_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_DIS |-> !q.out)
        else $error("disabled channel drives its output");

    a_event_wins: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        stat_rd && events[EV_CMP] |=> q.stat[EV_CMP])
        else $error("compare event lost on status read");

    // per-mode reactions to compare events, mode writes and the fault flag; event checks leave out halted cycles and control register writes
    a_toggle_event: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_TOGGLE && ev && !halt && !ctrl_wr |=> q.out != $past(q.out) && q.stat[EV_CMP])
        else $error("toggle compare event missed");

    a_set_low_ev: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_SET_LO && ev && !halt && !ctrl_wr |=> !q.out)
        else $error("set-low compare event did not force the output low");

    a_timer2_base: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !q.tsel && !halt && q.mode == M_TOGGLE && timer2_i.count == q.cmp && !q.match_prev && !ctrl_wr
        |=> q.out != $past(q.out))
        else $error("timer 2 compare did not toggle the output");

    a_no_match_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_SET_HI && !ev && !ctrl_wr |=> $stable(q.out))
        else $error("output moved without a compare event");

    a_single_rise: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_SINGLE && q.pulse == PS_ARMED && ev && !halt && !ctrl_wr |=> q.out && q.pulse == PS_HIGH)
        else $error("single pulse did not rise on the compare");

    a_cont_init_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ctrl_wr && pwdata[MODE_LSB+:3] == M_CONT && q.mode != M_CONT |=> !q.out && q.pulse == PS_ARMED)
        else $error("continuous pulse mode did not start low");

    a_set_high_init: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ctrl_wr && pwdata[MODE_LSB+:3] == M_SET_HI && q.mode != M_SET_HI |=> !q.out)
        else $error("set-high mode did not start low");

    a_fault_held: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_PWM_FLT && q.flt && !tm.period && !ctrl_wr |=> q.flt)
        else $error("fault flag cleared outside a period start");

    a_pwm_duty_fall: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        q.mode == M_PWM && !tm.period && dev && !halt && !ctrl_wr |=> !q.out)
        else $error("pwm output did not fall at the duty match");
endmodule : output_compare_channel

// ---- testbench/load_model.sv ----
// Purpose: external load on the compare output, counts rising edges it sees
// Assumes: the output has already been routed to a pin before the load relies on it
// Notes: behavioural only; the load never drives back into the channel
`timescale 1ns/1ns
module load_model (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    output logic [7:0] rise_o
);
    logic last_q;
    // edge counter; the bench reads it to tell one pulse from a train
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_q <= 1'b0;
            rise_o <= 8'h00;
        end else begin
            last_q <= pin_i;
            if (pin_i && !last_q) rise_o <= rise_o + 8'h01;
        end
    end
endmodule : load_model

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for one compare channel behind APB
// Assumes: channel one, so fault input a is its fault source
// Notes: timers are driven by the bench, counts held at zero between hits
`timescale 1ns/1ns
module tb;
    import cmp_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, idle, fa_n, fb_n, pin, irq, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] rises;
    timer_s t2, t3;
    int mismatches, checks;
    typedef struct packed {logic [2:0] m; logic ts; logic i0; logic a1; logic a2;} row_s;
    // mode, time base, level after mode write, after first and second compare hit
    row_s rows[4] = '{'{3'h1, 1'b0, 1'b0, 1'b1, 1'b1}, '{3'h2, 1'b1, 1'b1, 1'b0, 1'b0},
                      '{3'h3, 1'b1, 1'b0, 1'b1, 1'b0}, '{3'h0, 1'b0, 1'b0, 1'b0, 1'b0}};

    output_compare_channel #(.CHANNEL(1)) u_dut (.ref_clk_i(clk), .resetn_i(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer2_i(t2), .timer3_i(t3), .cpu_idle_i(idle),
        .fault_input_a_n_i(fa_n), .fault_input_b_n_i(fb_n), .compare_output_pin_o(pin), .irq_o(irq));
    load_model u_load (.ref_clk_i(clk), .resetn_i(rst_n), .pin_i(pin), .rise_o(rises));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_sim();
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one apb transfer; data and error taken at the edge that sees pready
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one cycle of an equal count on the chosen timer, then let the output settle
    task automatic hit(input logic ts, input logic [15:0] v);
        @(posedge clk);
        if (ts) t3.count <= v;
        else t2.count <= v;
        @(posedge clk);
        t2.count <= 16'h0000;
        t3.count <= 16'h0000;
        repeat (2) @(posedge clk);
        #1;
    endtask : hit

    task automatic per();
        @(posedge clk);
        t2.period <= 1'b1;
        @(posedge clk);
        t2.period <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : per

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic pulse(input logic [2:0] m, input logic third);
        logic [7:0] r0;
        apb(1'b1, CTRL_OFS, {29'h0, m});
        wt(2);
        chk("pulse init", pin, 1'b0);
        r0 = rises;
        hit(1'b0, 16'h0010);
        chk("pulse rise", pin, 1'b1);
        hit(1'b0, 16'h0020);
        chk("pulse fall", pin, 1'b0);
        hit(1'b0, 16'h0010);
        chk("pulse again", pin, third);
        chk("pulse count", rises - r0, third ? 8'h02 : 8'h01);
    endtask : pulse

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, idle} = 4'h0;
        {fa_n, fb_n} = 2'h3;
        paddr = 8'h00;
        pwdata = 32'h0;
        t2 = '0;
        t3 = '0;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and an unmapped place
        chk("ready idle", pready, 1'b1);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl rst", rd, 32'h0);
        apb(1'b0, CMP_OFS, 32'h0);
        chk("cmp rst", rd, 32'h0);
        apb(1'b0, MASK_OFS, 32'h0);
        chk("mask rst", rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, CMP_OFS, 32'h0010);
        apb(1'b1, SEC_OFS, 32'h0020);
        // basic modes: the other timer must not move the output
        foreach (rows[i]) begin
            apb(1'b1, CTRL_OFS, {28'h0, rows[i].ts, rows[i].m});
            wt(2);
            chk("mode init", pin, rows[i].i0);
            hit(~rows[i].ts, 16'h0010);
            chk("other base", pin, rows[i].i0);
            hit(rows[i].ts, 16'h0010);
            chk("first hit", pin, rows[i].a1);
            hit(rows[i].ts, 16'h0010);
            chk("second hit", pin, rows[i].a2);
        end
        pulse(3'h4, 1'b0);
        pulse(3'h5, 1'b1);
        // pwm ignoring the fault pin
        apb(1'b1, CTRL_OFS, 32'h6);
        per();
        chk("pwm high", pin, 1'b1);
        fa_n <= 1'b0;
        wt(8);
        chk("pwm no fault", pin, 1'b1);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("flag unused", rd[FLT_BIT], 1'b0);
        hit(1'b0, 16'h0020);
        chk("pwm duty", pin, 1'b0);
        fa_n <= 1'b1;
        // let the released pin pass the synchroniser before fault mode is entered
        wt(6);
        // pwm with fault; the b pin does not serve channel one
        apb(1'b1, CTRL_OFS, 32'h7);
        per();
        chk("pwmf high", pin, 1'b1);
        fb_n <= 1'b0;
        wt(8);
        chk("fault b", pin, 1'b1);
        fb_n <= 1'b1;
        fa_n <= 1'b0;
        wt(8);
        chk("fault stop", pin, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h7);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("flag stays", rd[FLT_BIT], 1'b1);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("fault event", rd[EV_FLT], 1'b1);
        fa_n <= 1'b1;
        wt(8);
        per();
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("flag hw clear", rd[FLT_BIT], 1'b0);
        // idle stop
        apb(1'b1, CTRL_OFS, 32'h2003);
        idle <= 1'b1;
        hit(1'b0, 16'h0010);
        chk("idle halt", pin, 1'b0);
        idle <= 1'b0;
        hit(1'b0, 16'h0010);
        chk("idle resume", pin, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h0003);
        idle <= 1'b1;
        hit(1'b0, 16'h0010);
        chk("idle run", pin, 1'b0);
        idle <= 1'b0;
        // interrupt: unmasked, cleared by read, then masked
        apb(1'b0, STAT_OFS, 32'h0);
        apb(1'b1, MASK_OFS, 32'h1);
        hit(1'b0, 16'h0010);
        chk("irq set", irq, 1'b1);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("stat cmp", rd, 32'h1);
        wt(1);
        chk("irq clear", irq, 1'b0);
        apb(1'b1, MASK_OFS, 32'h0);
        hit(1'b0, 16'h0010);
        chk("irq masked", irq, 1'b0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("stat masked", rd, 32'h1);
        // an event landing on the clearing edge of a status read survives it
        fork
            apb(1'b0, STAT_OFS, 32'h0);
            begin
                @(posedge clk);
                hit(1'b0, 16'h0010);
            end
        join
        chk("stat race read", rd, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("stat race kept", rd, 32'h1);
        // mid-run reset returns the output low
        rst_n <= 1'b0;
        wt(2);
        chk("reset pin", pin, 1'b0);
        end_sim();
    end
endmodule : tb
